// ==== shared/obc_pkg.sv ====
// Constants, types and decode functions shared by the option-byte decoder and its store.
// Assumes one system clock; option bytes are eight bits wide.
package obc_pkg;

  // ==========================================================================
  // Byte indices and field positions
  localparam int OBC_NUM_BYTES = 2;
  localparam logic [0:0] OBC_IDX_PKG = 1'h0;
  localparam logic [0:0] OBC_IDX_CLK = 1'h1;
  localparam int OBC_BIT_PROTECT = 0;
  localparam int OBC_BIT_PKGWIDE = 1;
  localparam int OBC_BIT_CSSDIS = 7;
  localparam int OBC_OSC_MSB = 6;
  localparam int OBC_OSC_LSB = 4;
  localparam int OBC_LVD_MSB = 3;
  localparam int OBC_LVD_LSB = 2;
  localparam int OBC_BIT_WDGHALT = 1;
  localparam int OBC_BIT_WDGSW = 0;

  // ==========================================================================
  // Byte values
  localparam logic [7:0] OBC_BLANK = 8'hff;
  localparam logic [7:0] OBC_WIPED = 8'h00;
  localparam logic [7:0] OBC_RSVD_MASK = 8'hfc;

  // ==========================================================================
  // Field encodings
  localparam logic [2:0] OBC_OSC_EXTCLK = 3'h7;
  localparam logic [2:0] OBC_OSC_INTRC = 3'h6;
  localparam logic [2:0] OBC_OSC_LP = 3'h3;
  localparam logic [2:0] OBC_OSC_MP = 3'h2;
  localparam logic [2:0] OBC_OSC_MS = 3'h1;
  localparam logic [2:0] OBC_OSC_HS = 3'h0;
  localparam logic [1:0] OBC_LVD_OFF = 2'h3;
  localparam logic [1:0] OBC_LVD_HIGH = 2'h2;
  localparam logic [1:0] OBC_LVD_MID = 2'h1;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    OBC_SRC_EXT_CLOCK, OBC_SRC_INT_RC, OBC_SRC_EXT_RC,
    OBC_SRC_RES_LP, OBC_SRC_RES_MP, OBC_SRC_RES_MS, OBC_SRC_RES_HS
  } obc_osc_t;

  typedef enum logic [1:0] {OBC_LVL_LOW, OBC_LVL_MID, OBC_LVL_HIGH} obc_lvd_t;

  typedef enum logic [1:0] {OBC_ST_RD0, OBC_ST_RD1, OBC_ST_CAP, OBC_ST_RUN} obc_state_t;

  // ==========================================================================
  // Decoders
  function automatic obc_osc_t obc_osc_decode(input logic [2:0] code);
    case (code)
      OBC_OSC_EXTCLK: obc_osc_decode = OBC_SRC_EXT_CLOCK;
      OBC_OSC_INTRC: obc_osc_decode = OBC_SRC_INT_RC;
      OBC_OSC_LP: obc_osc_decode = OBC_SRC_RES_LP;
      OBC_OSC_MP: obc_osc_decode = OBC_SRC_RES_MP;
      OBC_OSC_MS: obc_osc_decode = OBC_SRC_RES_MS;
      OBC_OSC_HS: obc_osc_decode = OBC_SRC_RES_HS;
      default: obc_osc_decode = OBC_SRC_EXT_RC;
    endcase
  endfunction

  function automatic obc_lvd_t obc_lvd_decode(input logic [1:0] code);
    case (code)
      OBC_LVD_HIGH: obc_lvd_decode = OBC_LVL_HIGH;
      OBC_LVD_MID: obc_lvd_decode = OBC_LVL_MID;
      default: obc_lvd_decode = OBC_LVL_LOW;
    endcase
  endfunction

endpackage

// ==== design/obc_opt_store.sv ====
// Non-volatile option-byte store: byte write, erase to zero, registered read.
// Assumes pwrOnRst models the blank state of fresh storage; system reset leaves it alone.
`timescale 1ns/1ns
module obc_opt_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2,
  parameter int ADDR_W = 1
) (
  // Clock and storage reset
  input wire logic core_clk,
  input wire logic pwrOnRst,
  // Access
  input wire logic wrEn,
  input wire logic erase,
  input wire logic rdEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] rdData
);
  import obc_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0] rdData;
  } obc_mem_st_t;

  localparam obc_mem_st_t OBC_MEM_RST = '{cells: {DEPTH{OBC_BLANK}}, rdData: '0};

  if (WIDTH != 8 || DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_chk
    $error("obc_opt_store: unsupported WIDTH, DEPTH or ADDR_W");
  end

  obc_mem_st_t st;
  obc_mem_st_t next_st;

  always_comb begin
    next_st = st;
    // Erase wins over a write in the same cycle
    if (erase) begin
      next_st.cells[addr] = OBC_WIPED;
    end else if (wrEn) begin
      next_st.cells[addr] = wrData;
    end
    if (rdEn) begin
      next_st.rdData = st.cells[addr];
    end
  end

  always_ff @(posedge core_clk or posedge pwrOnRst) begin
    if (pwrOnRst) begin
      st <= OBC_MEM_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdData = st.rdData;

  // ==========================================================================
  // Checks
  a_blank_after_power: assert property (@(posedge core_clk) disable iff (pwrOnRst)
    $fell(pwrOnRst) |-> st.cells == {DEPTH{OBC_BLANK}})
    else $error("storage not blank after power-on");

  a_erase_wipes_cell: assert property (@(posedge core_clk) disable iff (pwrOnRst)
    erase |=> st.cells[$past(addr)] == OBC_WIPED)
    else $error("erased byte not zero");

endmodule

// ==== design/obc_option_decoder.sv ====
// Option-byte decoder: loads both option bytes after reset, decodes and holds them,
// and serves programming-mode access to the bytes with read-out protection.
// Assumes program strobes come from an on-chip programming controller on core_clk;
// the programming-mode pin is asynchronous.
//
// Summary of operation
// - Option bytes are unmapped for the CPU; access only in programming mode.
// - Unprogrammed flash option storage reads as all ones.
// - Byte 0 bit 1 picks pinout: zero 42/44 pins, one 56/64 pins.
// - Byte 0 bit 0 set blocks external program memory access.
// - Clearing the protection bit erases program memory and option byte to zero.
// - Data EEPROM stays externally accessible regardless of protection.
// - Byte 1 bit 7 zero enables clock monitor, one disables it.
// - Byte 1 bits 6:4 select the main oscillator source.
// - Byte 1 bits 3:2 enable low-voltage detector and pick threshold.
// - Byte 1 bit 1 set makes halt entry reset under active watchdog.
// - Byte 1 bit 0 zero forces hardware watchdog, one leaves it to software.
// - Masked-ROM parts take fixed factory options, never reprogrammed.
// - Oscillator codes: 111 ext clock, 110 int RC, 10x ext RC, 011-000 resonators.
// - Detector codes: 11 off, 10 highest, 01 medium, 00 lowest threshold.
`timescale 1ns/1ns
module obc_option_decoder #(
  parameter bit ROM_DEVICE = 1'b0,
  parameter logic [7:0] FACTORY_OPT0 = 8'hff,
  parameter logic [7:0] FACTORY_OPT1 = 8'hff
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pwrOnRst,
  // Programming access
  input wire logic progModePin,
  input wire logic progWrEn,
  input wire logic progRdEn,
  input wire logic progByteSel,
  input wire logic [7:0] progWrData,
  output logic [7:0] progRdData,
  output logic progRdValid,
  // Access control towards the memories
  output logic readoutProtect,
  output logic progMemAccessAllow,
  output logic eepromAccessAllow,
  output logic massErase,
  // Decoded options
  output logic optionsValid,
  output logic packageWide,
  output logic clockMonitorDisable,
  output obc_pkg::obc_osc_t oscillatorSource,
  output logic lvdEnable,
  output obc_pkg::obc_lvd_t lvdLevel,
  output logic watchdogHaltReset,
  output logic watchdogSoftwareMode,
  output logic watchdogHwEnable
);
  import obc_pkg::*;

  // Reserved bits in the factory code must be ones
  if ((FACTORY_OPT0 & OBC_RSVD_MASK) != OBC_RSVD_MASK) begin : g_chk
    $error("obc_option_decoder: FACTORY_OPT0 reserved bits must be ones");
  end

  typedef struct packed {
    obc_state_t state;
    logic modeMeta;
    logic modeSync;
    logic [7:0] opt0;
    logic [7:0] opt1;
    logic liveProtect;
    logic rdPending;
    logic rdSel;
    logic [7:0] progRdData;
    logic progRdValid;
    logic progMemAccessAllow;
    logic eepromAccessAllow;
    logic massErase;
    logic optionsValid;
    logic packageWide;
    logic clockMonitorDisable;
    obc_osc_t oscillatorSource;
    logic lvdEnable;
    obc_lvd_t lvdLevel;
    logic watchdogHaltReset;
    logic watchdogSoftwareMode;
    logic watchdogHwEnable;
  } obc_top_st_t;

  obc_top_st_t st;
  obc_top_st_t next_st;
  logic memRdEn;
  logic memWrEn;
  logic memErase;
  logic [0:0] memAddr;
  logic [7:0] memRdData;
  logic progOk;
  logic [7:0] byte1;

  // ==========================================================================
  // Option storage
  obc_opt_store #(.WIDTH(8), .DEPTH(OBC_NUM_BYTES), .ADDR_W(1)) u_store (
    .core_clk(core_clk),
    .pwrOnRst(pwrOnRst),
    .wrEn(memWrEn),
    .erase(memErase),
    .rdEn(memRdEn),
    .addr(memAddr),
    .wrData(progWrData),
    .rdData(memRdData)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    memRdEn = 1'b0;
    memWrEn = 1'b0;
    memErase = 1'b0;
    memAddr = OBC_IDX_PKG;
    byte1 = ROM_DEVICE ? FACTORY_OPT1 : memRdData;
    // Programming requests only count once options are loaded and the pin says so
    progOk = (st.state == OBC_ST_RUN) && st.modeSync;
    next_st.modeMeta = progModePin;
    next_st.modeSync = st.modeMeta;
    next_st.massErase = 1'b0;
    next_st.progRdValid = 1'b0;
    next_st.rdPending = 1'b0;
    case (st.state)
      OBC_ST_RD0: begin
        memRdEn = 1'b1;
        memAddr = OBC_IDX_PKG;
        next_st.state = OBC_ST_RD1;
      end
      OBC_ST_RD1: begin
        memRdEn = 1'b1;
        memAddr = OBC_IDX_CLK;
        next_st.opt0 = ROM_DEVICE ? FACTORY_OPT0 : memRdData;
        next_st.state = OBC_ST_CAP;
      end
      OBC_ST_CAP: begin
        next_st.opt1 = byte1;
        next_st.liveProtect = st.opt0[OBC_BIT_PROTECT];
        next_st.packageWide = st.opt0[OBC_BIT_PKGWIDE];
        next_st.clockMonitorDisable = byte1[OBC_BIT_CSSDIS];
        next_st.oscillatorSource = obc_osc_decode(byte1[OBC_OSC_MSB:OBC_OSC_LSB]);
        next_st.lvdEnable = byte1[OBC_LVD_MSB:OBC_LVD_LSB] != OBC_LVD_OFF;
        next_st.lvdLevel = obc_lvd_decode(byte1[OBC_LVD_MSB:OBC_LVD_LSB]);
        next_st.watchdogHaltReset = byte1[OBC_BIT_WDGHALT];
        next_st.watchdogSoftwareMode = byte1[OBC_BIT_WDGSW];
        next_st.watchdogHwEnable = !byte1[OBC_BIT_WDGSW];
        next_st.optionsValid = 1'b1;
        next_st.state = OBC_ST_RUN;
      end
      OBC_ST_RUN: begin
        // Decoded options stay frozen here; only storage and protection move
        if (st.rdPending) begin
          next_st.progRdValid = 1'b1;
          if (ROM_DEVICE) begin
            next_st.progRdData = st.rdSel ? FACTORY_OPT1 : FACTORY_OPT0;
          end else begin
            next_st.progRdData = memRdData;
          end
        end
        if (progOk && progRdEn) begin
          memRdEn = 1'b1;
          memAddr = progByteSel;
          next_st.rdPending = 1'b1;
          next_st.rdSel = progByteSel;
        end else if (progOk && progWrEn && !ROM_DEVICE) begin
          memWrEn = 1'b1;
          memAddr = progByteSel;
          if (progByteSel == OBC_IDX_PKG) begin
            if (st.liveProtect && !progWrData[OBC_BIT_PROTECT]) begin
              // Dropping protection wipes byte 0 and raises massErase instead of writing, so no code leaks out
              memErase = 1'b1;
              next_st.massErase = 1'b1;
              next_st.liveProtect = 1'b0;
            end else begin
              next_st.liveProtect = progWrData[OBC_BIT_PROTECT];
            end
          end
        end
      end
      default: begin
        next_st.state = OBC_ST_RD0;
      end
    endcase
    next_st.progMemAccessAllow = progOk && !next_st.liveProtect;
    next_st.eepromAccessAllow = progOk;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  assign progRdData = st.progRdData;
  assign progRdValid = st.progRdValid;
  assign readoutProtect = st.liveProtect;
  assign progMemAccessAllow = st.progMemAccessAllow;
  assign eepromAccessAllow = st.eepromAccessAllow;
  assign massErase = st.massErase;
  assign optionsValid = st.optionsValid;
  assign packageWide = st.packageWide;
  assign clockMonitorDisable = st.clockMonitorDisable;
  assign oscillatorSource = st.oscillatorSource;
  assign lvdEnable = st.lvdEnable;
  assign lvdLevel = st.lvdLevel;
  assign watchdogHaltReset = st.watchdogHaltReset;
  assign watchdogSoftwareMode = st.watchdogSoftwareMode;
  assign watchdogHwEnable = st.watchdogHwEnable;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_load;
    st.state == OBC_ST_RD0 ##1 st.state == OBC_ST_RD1 ##1 st.state == OBC_ST_CAP;
  endsequence

  a_load_then_valid: assert property (st.state == OBC_ST_RD0 |-> s_load ##1 optionsValid)
    else $error("options not valid three cycles after load start");

  a_options_held: assert property (optionsValid |=> optionsValid && $stable(oscillatorSource)
    && $stable(lvdLevel) && $stable(watchdogHwEnable) && $stable(packageWide))
    else $error("decoded options changed after load");

  a_prog_mode_only: assert property ((progRdValid || memWrEn) |-> $past(st.modeSync, 2) || st.modeSync)
    else $error("option access outside programming mode");

  a_protect_blocks: assert property (readoutProtect |-> !progMemAccessAllow)
    else $error("program memory open while protected");

  a_erase_on_clear: assert property ($fell(readoutProtect) && optionsValid && $past(optionsValid)
    |-> massErase)
    else $error("protection cleared without mass erase");

  a_eeprom_open: assert property ((st.state == OBC_ST_RUN) && st.modeSync |=> eepromAccessAllow)
    else $error("eeprom closed in programming mode");

  a_package_field: assert property (optionsValid |-> packageWide == st.opt0[OBC_BIT_PKGWIDE])
    else $error("package option mismatch");

  a_monitor_field: assert property (optionsValid |-> clockMonitorDisable == st.opt1[OBC_BIT_CSSDIS])
    else $error("clock monitor option mismatch");

  a_ext_rc_code: assert property (optionsValid && st.opt1[OBC_OSC_MSB -: 2] == 2'h2
    |-> oscillatorSource == OBC_SRC_EXT_RC)
    else $error("external RC code misdecoded");

  a_lvd_off_code: assert property (optionsValid |-> lvdEnable == (st.opt1[OBC_LVD_MSB:OBC_LVD_LSB] != 2'h3))
    else $error("detector enable misdecoded");

  a_halt_reset_bit: assert property (optionsValid |-> watchdogHaltReset == st.opt1[OBC_BIT_WDGHALT])
    else $error("halt reset option mismatch");

  a_wdg_type: assert property (optionsValid |-> watchdogHwEnable != watchdogSoftwareMode)
    else $error("watchdog type outputs disagree");

  a_rom_no_write: assert property (ROM_DEVICE |-> !memWrEn && !massErase)
    else $error("masked-ROM option changed");

endmodule

// ==== tb/obc_prog_tool.sv ====
// Programming tool model: drives the programming strobes and mode pin of the option decoder.
// Assumes the decoder samples on the rising edge of core_clk; every change lands 1 ns after it.
`timescale 1ns/1ns
module obc_prog_tool (
  // Clock and answers
  input wire logic core_clk,
  input wire logic [7:0] progRdData,
  input wire logic progRdValid,
  // Strobes
  output logic progModePin,
  output logic progWrEn,
  output logic progRdEn,
  output logic progByteSel,
  output logic [7:0] progWrData
);
  import obc_pkg::*;

  initial begin
    progModePin = 1'b0;
    progWrEn = 1'b0;
    progRdEn = 1'b0;
    progByteSel = 1'b0;
    progWrData = 8'h00;
  end

  // ==========================================================================
  // Mode pin: the bytes are reachable only while it is high
  task automatic set_mode(input logic on);
    @(posedge core_clk);
    #1 progModePin = on;
  endtask

  // ==========================================================================
  // Write: released lines show the inverse so a stale value never looks valid
  task automatic write_byte(input logic sel, input logic [7:0] data);
    logic [7:0] value;
    value = sel ? data : (data | OBC_RSVD_MASK);
    @(posedge core_clk);
    #1;
    progWrEn = 1'b1;
    progByteSel = sel;
    progWrData = value;
    @(posedge core_clk);
    #1;
    progWrEn = 1'b0;
    progByteSel = ~sel;
    progWrData = ~value;
  endtask

  // ==========================================================================
  // Read: lat counts edges after the taking edge, 5 means no answer
  task automatic read_byte(input logic sel, output logic [7:0] data, output int lat);
    @(posedge core_clk);
    #1;
    progRdEn = 1'b1;
    progByteSel = sel;
    @(posedge core_clk);
    #1;
    progRdEn = 1'b0;
    progByteSel = ~sel;
    lat = 0;
    while (lat < 5 && progRdValid !== 1'b1) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    data = progRdData;
  endtask
endmodule

// ==== tb/obc_option_decoder_bench.sv ====
// Self-checking bench for the option-byte decoder, driven through the programming tool model.
// Assumes a 100 MHz core_clk and that storage starts blank under pwrOnRst.
`timescale 1ns/1ns
module obc_option_decoder_bench;
  import obc_pkg::*;
  logic core_clk, sys_rst, pwrOnRst;
  logic progModePin, progWrEn, progRdEn, progByteSel, progRdValid;
  logic [7:0] progWrData, progRdData;
  logic readoutProtect, progMemAccessAllow, eepromAccessAllow, massErase;
  logic optionsValid, packageWide, clockMonitorDisable, lvdEnable;
  logic watchdogHaltReset, watchdogSoftwareMode, watchdogHwEnable;
  obc_osc_t oscillatorSource;
  obc_lvd_t lvdLevel;
  logic [7:0] opt0 = 8'hff;
  logic [7:0] opt1 = 8'hff;
  logic [7:0] romRdData;
  logic romMassErase, romPackageWide;
  obc_osc_t romOsc;
  int num_errors = 0;
  int num_checks = 0;

  obc_option_decoder dut (.core_clk(core_clk), .sys_rst(sys_rst), .pwrOnRst(pwrOnRst),
    .progModePin(progModePin), .progWrEn(progWrEn), .progRdEn(progRdEn), .progByteSel(progByteSel),
    .progWrData(progWrData), .progRdData(progRdData), .progRdValid(progRdValid),
    .readoutProtect(readoutProtect), .progMemAccessAllow(progMemAccessAllow),
    .eepromAccessAllow(eepromAccessAllow), .massErase(massErase), .optionsValid(optionsValid),
    .packageWide(packageWide), .clockMonitorDisable(clockMonitorDisable),
    .oscillatorSource(oscillatorSource), .lvdEnable(lvdEnable), .lvdLevel(lvdLevel),
    .watchdogHaltReset(watchdogHaltReset), .watchdogSoftwareMode(watchdogSoftwareMode),
    .watchdogHwEnable(watchdogHwEnable));

  // Factory-coded twin on the same strobes; its options come from the codes below
  obc_option_decoder #(.ROM_DEVICE(1'b1), .FACTORY_OPT0(8'hfd), .FACTORY_OPT1(8'h5a)) dutRom (
    .core_clk(core_clk), .sys_rst(sys_rst), .pwrOnRst(pwrOnRst), .progModePin(progModePin),
    .progWrEn(progWrEn), .progRdEn(progRdEn), .progByteSel(progByteSel), .progWrData(progWrData),
    .progRdData(romRdData), .progRdValid(), .readoutProtect(), .progMemAccessAllow(), .eepromAccessAllow(),
    .massErase(romMassErase), .optionsValid(), .packageWide(romPackageWide), .clockMonitorDisable(),
    .oscillatorSource(romOsc), .lvdEnable(), .lvdLevel(), .watchdogHaltReset(), .watchdogSoftwareMode(),
    .watchdogHwEnable());

  obc_prog_tool tool (.core_clk(core_clk), .progRdData(progRdData), .progRdValid(progRdValid),
    .progModePin(progModePin), .progWrEn(progWrEn), .progRdEn(progRdEn), .progByteSel(progByteSel),
    .progWrData(progWrData));

  // ==========================================================================
  // Compare, verdict and reset helpers
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic checkBit(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic summarize();
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic blank);
    int n;
    @(posedge core_clk);
    #1;
    sys_rst = 1'b1;
    pwrOnRst = blank;
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    pwrOnRst = 1'b0;
    n = 0;
    while (n < 20 && optionsValid !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    checkBit(optionsValid, 1'b1);
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic check_options(input logic [7:0] b0, input logic [7:0] b1);
    obc_osc_t osc;
    obc_lvd_t lvl;
    case (b1[6:4])
      3'h7: osc = OBC_SRC_EXT_CLOCK;
      3'h6: osc = OBC_SRC_INT_RC;
      3'h5, 3'h4: osc = OBC_SRC_EXT_RC;
      3'h3: osc = OBC_SRC_RES_LP;
      3'h2: osc = OBC_SRC_RES_MP;
      3'h1: osc = OBC_SRC_RES_MS;
      default: osc = OBC_SRC_RES_HS;
    endcase
    lvl = (b1[3:2] == 2'h2) ? OBC_LVL_HIGH : ((b1[3:2] == 2'h1) ? OBC_LVL_MID : OBC_LVL_LOW);
    checkBit(packageWide, b0[1]);
    checkBit(clockMonitorDisable, b1[7]);
    check8({5'h00, oscillatorSource}, {5'h00, osc});
    checkBit(lvdEnable, b1[3:2] != 2'h3);
    check8({6'h00, lvdLevel}, {6'h00, lvl});
    checkBit(watchdogHaltReset, b1[1]);
    checkBit(watchdogSoftwareMode, b1[0]);
    checkBit(watchdogHwEnable, ~b1[0]);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_blank();
    logic [7:0] d;
    int lat;
    check_options(OBC_BLANK, OBC_BLANK);
    checkBit(progMemAccessAllow, 1'b0);
    checkBit(eepromAccessAllow, 1'b0);
    tool.read_byte(1'b1, d, lat);
    check8(8'(lat), 8'h05);
    tool.set_mode(1'b1);
    repeat (4) @(posedge core_clk);
    #1;
    checkBit(readoutProtect, 1'b1);
    checkBit(progMemAccessAllow, 1'b0);
    checkBit(eepromAccessAllow, 1'b1);
    for (int s = 0; s < 2; s++) begin
      tool.read_byte(s[0], d, lat);
      check8(8'(lat), 8'h01);
      check8(d, OBC_BLANK);
    end
  endtask

  // Every oscillator and detector code, held until the next reset
  task automatic test_codes();
    logic [7:0] d;
    int lat;
    for (int i = 0; i < 8; i++) begin
      tool.write_byte(1'b1, {i[0], i[2:0], i[1:0], i[1], i[0]});
      tool.read_byte(1'b1, d, lat);
      check8(d, {i[0], i[2:0], i[1:0], i[1], i[0]});
      check_options(opt0, opt1);
      opt1 = d;
      do_reset(1'b0);
      check_options(opt0, opt1);
    end
  endtask

  task automatic test_erase();
    logic [7:0] d;
    int lat;
    tool.write_byte(1'b0, 8'h02);
    checkBit(massErase, 1'b1);
    checkBit(readoutProtect, 1'b0);
    checkBit(progMemAccessAllow, 1'b1);
    @(posedge core_clk);
    #1;
    checkBit(massErase, 1'b0);
    tool.read_byte(1'b0, d, lat);
    check8(d, OBC_WIPED);
    do_reset(1'b0);
    check_options(OBC_WIPED, opt1);
    tool.write_byte(1'b0, 8'h02);
    checkBit(massErase, 1'b0);
    tool.read_byte(1'b0, d, lat);
    check8(d, 8'hfe);
    do_reset(1'b0);
    check_options(8'hfe, opt1);
    checkBit(readoutProtect, 1'b0);
    tool.write_byte(1'b0, 8'h03);
    checkBit(readoutProtect, 1'b1);
    checkBit(progMemAccessAllow, 1'b0);
    checkBit(eepromAccessAllow, 1'b1);
  endtask

  task automatic test_mode_low();
    logic [7:0] d;
    int lat;
    tool.set_mode(1'b0);
    repeat (4) @(posedge core_clk);
    #1;
    checkBit(eepromAccessAllow, 1'b0);
    checkBit(progMemAccessAllow, 1'b0);
    tool.write_byte(1'b1, 8'h00);
    tool.set_mode(1'b1);
    repeat (4) @(posedge core_clk);
    tool.read_byte(1'b1, d, lat);
    check8(d, opt1);
  endtask

  // Factory-coded options ignore writes and erase, and read back as coded
  task automatic test_rom();
    logic [7:0] d;
    int lat;
    tool.write_byte(1'b0, 8'h00);
    checkBit(massErase, 1'b1);
    checkBit(romMassErase, 1'b0);
    tool.read_byte(1'b1, d, lat);
    check8(romRdData, 8'h5a);
    do_reset(1'b0);
    checkBit(romPackageWide, 1'b0);
    check8({5'h00, romOsc}, {5'h00, OBC_SRC_EXT_RC});
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // The whole run needs well under 2000 cycles
  initial begin
    #200000;
    num_errors++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    pwrOnRst = 1'b1;
    do_reset(1'b1);
    test_blank();
    test_codes();
    test_erase();
    test_mode_low();
    test_rom();
    summarize();
  end
endmodule
